/* amst_defines.vh */
`ifndef AMST_DEFINES_VH
`define AMST_DEFINES_VH
// ************************************************************
// register indices (printed offsets, byte address = 4 * index)
// ************************************************************
`define AMST_IDX_ALARM_SUMMARY  10'h2C0
`define AMST_IDX_ALARM_STATUS   10'h2C1
`define AMST_IDX_ALARM_MASK     10'h2C2
`define AMST_IDX_LANE_FLAGS     10'h2C4
`define AMST_IDX_TRIM_A_DUAL    10'h310
`define AMST_IDX_TRIM_B_DUAL    10'h313
`define AMST_IDX_TRIM_A_SINGLE  10'h314
`define AMST_IDX_TRIM_B_SINGLE  10'h315
`define AMST_IDX_CTRL           10'h3F0
`define AMST_IDX_IRQ_STATUS     10'h3F1
`define AMST_IDX_IRQ_MASK       10'h3F2
// ************************************************************
// field positions and reset values
// ************************************************************
`define AMST_BIT_LANE_FIFO      5
`define AMST_ALARM_BITS         6
`define AMST_ALARM_MASK_RST     6'h3F
`define AMST_ALARM_STATUS_RST   6'h3F
`define AMST_LANES              16
`define AMST_LANE_FLAGS_RST     16'hFFFF
`define AMST_CTRL_CAL_SEL_BIT   0
`define AMST_IRQ_BITS           2
`define AMST_IRQ_ALARM_BIT      0
`define AMST_IRQ_LANE_BIT       1
`define AMST_IRQ_MASK_RST       2'h0
`define AMST_MODE_A_DUAL        2'h0
`define AMST_MODE_B_DUAL        2'h1
`define AMST_MODE_A_SINGLE_INA  2'h2
`define AMST_MODE_B_SINGLE_INA  2'h3
`endif

/* amst_regs.v */
// Our own choice: register access over Wishbone.
`include "amst_defines.vh"
`default_nettype none
// Operation
// - the alarm mask holds six bits (5 lane fifo down to 0 clock) and a set bit hides that alarm.
// - the alarm mask resets to 0x3F with reserved bits 7:6 at zero.
// - the sixteen-bit lane flag register sets bit i when lane i fifo overflows or underflows.
// - the lane flag register resets to 0xFFFF.
// - writing a one to a lane flag bit clears it.
// - a cleared lane flag sets again at once while its fault persists.
// - writing one to the lane fifo bit of alarm status clears all sixteen lane flags.
// - each sampling trim register holds an eight-bit sampling instant value.
// - trim registers load factory values as defaults and are readable and writable.
// - the applied trim is chosen by core and mode among the four trim registers.
// - the summary alarm reads one when any status bit is set with its mask clear.
// - the lane fifo status bit sets on any active lane fault and clears on a written one.
// - after reset or soft reset all alarm status bits are one.
// - a select bit routes the summary alarm to the calibration status pin.
module amst_regs #(
    parameter [7:0] TRIM_A_DUAL_FUSE   = 8'h00,
    parameter [7:0] TRIM_B_DUAL_FUSE   = 8'h00,
    parameter [7:0] TRIM_A_SINGLE_FUSE = 8'h00,
    parameter [7:0] TRIM_B_SINGLE_FUSE = 8'h00
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        soft_rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [11:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [5:0]  alarm_event_i,
    input  wire [15:0] lane_fault_i,
    input  wire [1:0]  trim_mode_i,
    output reg  [7:0]  sample_trim_o,
    output wire        cal_status_pin_o,
    output wire        irq_o
);
    // ************************************************************
    // bus decode
    // ************************************************************
    wire [9:0] idx      = wb_adr_i[11:2];
    wire       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wr       = req & wb_we_i;
    wire       wr_lo    = wr & wb_sel_i[0];
    wire       wr_hi    = wr & wb_sel_i[1];
    reg  [5:0]  alarm_mask_reg;
    reg  [5:0]  alarm_status_reg;
    reg  [15:0] lane_fifo_fault_flags_reg;
    reg  [7:0]  core_a_dual_sample_trim_reg;
    reg  [7:0]  core_b_dual_sample_trim_reg;
    reg  [7:0]  core_a_single_ina_sample_trim_reg;
    reg  [7:0]  core_b_single_ina_sample_trim_reg;
    reg         cal_sel_reg;
    reg  [1:0]  irq_status_reg;
    reg  [1:0]  irq_mask_reg;
    reg         alarm_d_reg;
    wire        st_wr   = wr_lo & (idx == `AMST_IDX_ALARM_STATUS);
    wire        lane_all_clr = st_wr & wb_dat_i[`AMST_BIT_LANE_FIFO];
    wire        lane_any = |lane_fault_i;
    wire [5:0]  events  = {alarm_event_i[5] | lane_any, alarm_event_i[4:0]};
    wire        alarm   = |(alarm_status_reg & ~alarm_mask_reg);
    wire [1:0]  irq_ev  = {lane_any, alarm & ~alarm_d_reg};
    reg  [15:0] lane_clr;
    reg  [15:0] lane_next;
    always @* begin
        lane_clr = 16'h0000;
        if (wr & (idx == `AMST_IDX_LANE_FLAGS)) begin
            lane_clr = wb_dat_i[15:0] & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        end
        if (lane_all_clr) begin
            lane_clr = 16'hFFFF;
        end
        lane_next = (lane_fifo_fault_flags_reg & ~lane_clr) | lane_fault_i;
    end
    assign cal_status_pin_o = cal_sel_reg & alarm;
    assign irq_o = |(irq_status_reg & irq_mask_reg);
    // ************************************************************
    // applied trim selection
    // ************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            sample_trim_o <= 8'h00;
        end else begin
            case (trim_mode_i)
                `AMST_MODE_A_DUAL:       sample_trim_o <= core_a_dual_sample_trim_reg;
                `AMST_MODE_B_DUAL:       sample_trim_o <= core_b_dual_sample_trim_reg;
                `AMST_MODE_A_SINGLE_INA: sample_trim_o <= core_a_single_ina_sample_trim_reg;
                default:                 sample_trim_o <= core_b_single_ina_sample_trim_reg;
            endcase
        end
    end
    // ************************************************************
    // registers
    // ************************************************************
    always @(posedge clk_i) begin
        if (rst_i | soft_rst_i) begin
            alarm_mask_reg            <= `AMST_ALARM_MASK_RST;
            alarm_status_reg          <= `AMST_ALARM_STATUS_RST;
            lane_fifo_fault_flags_reg <= `AMST_LANE_FLAGS_RST;
            core_a_dual_sample_trim_reg       <= TRIM_A_DUAL_FUSE;
            core_b_dual_sample_trim_reg       <= TRIM_B_DUAL_FUSE;
            core_a_single_ina_sample_trim_reg <= TRIM_A_SINGLE_FUSE;
            core_b_single_ina_sample_trim_reg <= TRIM_B_SINGLE_FUSE;
            cal_sel_reg               <= 1'b0;
            irq_status_reg            <= 2'h0;
            irq_mask_reg              <= `AMST_IRQ_MASK_RST;
            alarm_d_reg               <= 1'b0;
        end else begin
            alarm_d_reg               <= alarm;
            lane_fifo_fault_flags_reg <= lane_next;
            // set beats clear on the same cycle
            alarm_status_reg <= (alarm_status_reg & ~(st_wr ? wb_dat_i[5:0] : 6'h00)) | events;
            irq_status_reg <= (irq_status_reg &
                ~((wr_lo & (idx == `AMST_IDX_IRQ_STATUS)) ? wb_dat_i[1:0] : 2'h0)) | irq_ev;
            if (wr_lo) begin
                case (idx)
                    `AMST_IDX_ALARM_MASK:     alarm_mask_reg <= wb_dat_i[5:0];
                    `AMST_IDX_TRIM_A_DUAL:    core_a_dual_sample_trim_reg <= wb_dat_i[7:0];
                    `AMST_IDX_TRIM_B_DUAL:    core_b_dual_sample_trim_reg <= wb_dat_i[7:0];
                    `AMST_IDX_TRIM_A_SINGLE:  core_a_single_ina_sample_trim_reg <= wb_dat_i[7:0];
                    `AMST_IDX_TRIM_B_SINGLE:  core_b_single_ina_sample_trim_reg <= wb_dat_i[7:0];
                    `AMST_IDX_CTRL:           cal_sel_reg <= wb_dat_i[`AMST_CTRL_CAL_SEL_BIT];
                    `AMST_IDX_IRQ_MASK:       irq_mask_reg <= wb_dat_i[1:0];
                    default: ;
                endcase
            end
        end
    end
    // ************************************************************
    // bus answer, one wait-free cycle
    // ************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h00000000;
            if (req & ~wb_we_i) begin
                case (idx)
                    `AMST_IDX_ALARM_SUMMARY: wb_dat_o <= {31'h0, alarm};
                    `AMST_IDX_ALARM_STATUS:  wb_dat_o <= {26'h0, alarm_status_reg};
                    `AMST_IDX_ALARM_MASK:    wb_dat_o <= {26'h0, alarm_mask_reg};
                    `AMST_IDX_LANE_FLAGS:    wb_dat_o <= {16'h0, lane_fifo_fault_flags_reg};
                    `AMST_IDX_TRIM_A_DUAL:   wb_dat_o <= {24'h0, core_a_dual_sample_trim_reg};
                    `AMST_IDX_TRIM_B_DUAL:   wb_dat_o <= {24'h0, core_b_dual_sample_trim_reg};
                    `AMST_IDX_TRIM_A_SINGLE: wb_dat_o <= {24'h0, core_a_single_ina_sample_trim_reg};
                    `AMST_IDX_TRIM_B_SINGLE: wb_dat_o <= {24'h0, core_b_single_ina_sample_trim_reg};
                    `AMST_IDX_CTRL:          wb_dat_o <= {31'h0, cal_sel_reg};
                    `AMST_IDX_IRQ_STATUS:    wb_dat_o <= {30'h0, irq_status_reg};
                    `AMST_IDX_IRQ_MASK:      wb_dat_o <= {30'h0, irq_mask_reg};
                    default:                 wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // amst_regs
`default_nettype wire

/* amst_regs_sva.sv */
`include "amst_defines.vh"
`default_nettype none
// ****************
// register checker
// ****************
module amst_regs_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [5:0]  alarm_event_i,
    input wire logic [15:0] lane_fault_i,
    input wire logic        cal_status_pin_o,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [9:0] idx;
    assign idx = wb_adr_i[11:2];
    // read answer; data reflects inputs seen two edges before the ack edge
    sequence rd_at(logic [9:0] i);
        wb_ack_o && !wb_we_i && idx == i;
    endsequence
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_mask_width: assert property (rd_at(`AMST_IDX_ALARM_MASK) |-> wb_dat_o[31:6] == 26'h0)
        else $error("mask reserved bits not zero");
    a_trim_width: assert property (rd_at(`AMST_IDX_TRIM_A_DUAL) |-> wb_dat_o[31:8] == 24'h0)
        else $error("trim upper bits not zero");
    a_lane_sets: assert property (rd_at(`AMST_IDX_LANE_FLAGS) |->
        (wb_dat_o[15:0] & $past(lane_fault_i, 2)) == $past(lane_fault_i, 2))
        else $error("lane fault did not set its flag");
    a_status_sets: assert property (rd_at(`AMST_IDX_ALARM_STATUS) |-> (wb_dat_o[5:0]
        & $past(alarm_event_i, 2)) == $past(alarm_event_i, 2) && wb_dat_o[31:6] == 26'h0)
        else $error("alarm event did not set status");
    a_pin_reset: assert property ($fell(rst_i) |-> !cal_status_pin_o && !irq_o)
        else $error("pin or irq high after reset");
endmodule // amst_regs_sva
bind amst_regs amst_regs_sva amst_regs_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alarm_event_i(alarm_event_i),
    .lane_fault_i(lane_fault_i), .cal_status_pin_o(cal_status_pin_o), .irq_o(irq_o));
`default_nettype wire

/* testbench.sv */
`default_nettype none
// ***************
// register bench
// ***************
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic        wb_ack_o, cal_status_pin_o, irq_o;
    logic [5:0]  alarm_event_i = 6'h00;
    logic [15:0] lane_fault_i = 16'h0000;
    logic [1:0]  trim_mode_i = 2'h0;
    logic        soft_rst_i = 1'h0;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [7:0]  sample_trim_o;
    logic [11:0] trim_adr [4] = '{12'hC40, 12'hC4C, 12'hC50, 12'hC54};
    int          err_count = 0, cmp_count = 0;
    amst_regs amst_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .alarm_event_i(alarm_event_i), .lane_fault_i(lane_fault_i), .trim_mode_i(trim_mode_i),
        .sample_trim_o(sample_trim_o), .cal_status_pin_o(cal_status_pin_o), .irq_o(irq_o));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic give_verdict();
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // entered just after an edge; values read are those the edge sampled
    task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] dat);
        int n;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        if (wb_ack_o !== 1'h1) begin
            err_count++;
            give_verdict();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic rchk(input logic [11:0] adr, input logic [31:0] exp);
        bus(1'h0, adr, 32'h0);
        chk(rd, exp);
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        rchk(12'hB08, 32'h3F);
        rchk(12'hB10, 32'hFFFF);
        rchk(12'hB04, 32'h3F);
        rchk(12'hB00, 32'h0);
        rchk(12'h004, 32'h0);
        bus(1'h1, 12'hB10, 32'h00FF);
        rchk(12'hB10, 32'hFF00);
        lane_fault_i <= 16'h0002;
        bus(1'h1, 12'hB10, 32'hFFFF);
        lane_fault_i <= 16'h0000;
        rchk(12'hB10, 32'h0002);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'h1, 12'hB04, 32'h20);
        rchk(12'hB10, 32'h0);
        bus(1'h1, 12'hFC0, 32'h1);
        for (int i = 0; i < 6; i++) begin
            bus(1'h1, 12'hB04, 32'h3F);
            alarm_event_i <= 6'h01 << i;
            @(posedge clk_i);
            alarm_event_i <= 6'h00;
            rchk(12'hB04, 32'h1 << i);
            rchk(12'hB00, 32'h0);
            bus(1'h1, 12'hB08, 32'h3F & ~(32'h1 << i));
            rchk(12'hB00, 32'h1);
            chk({31'h0, cal_status_pin_o}, 32'h1);
            bus(1'h1, 12'hB08, 32'h3F);
        end
        bus(1'h1, 12'hFC8, 32'h3);
        chk({31'h0, irq_o}, 32'h1);
        bus(1'h1, 12'hFC4, 32'h3);
        chk({31'h0, irq_o}, 32'h0);
        for (int k = 0; k < 4; k++) begin
            rchk(trim_adr[k], 32'h0);
            bus(1'h1, trim_adr[k], 32'hA5 + k);
            trim_mode_i <= k[1:0];
            repeat (2) @(posedge clk_i);
            chk({24'h0, sample_trim_o}, 32'hA5 + k);
            rchk(trim_adr[k], 32'hA5 + k);
        end
        // soft reset must bring back the mask, status, lane flag and trim A dual defaults
        bus(1'h1, 12'hB08, 32'h0);
        soft_rst_i <= 1'h1;
        @(posedge clk_i);
        soft_rst_i <= 1'h0;
        @(posedge clk_i);
        rchk(12'hB08, 32'h3F);
        rchk(12'hB04, 32'h3F);
        rchk(12'hB10, 32'hFFFF);
        rchk(trim_adr[0], 32'h0);
        // a write without the low byte lane leaves the low flags alone
        wb_sel_i <= 4'h2;
        bus(1'h1, 12'hB10, 32'hFFFF);
        wb_sel_i <= 4'hF;
        rchk(12'hB10, 32'h00FF);
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
